// ==== emu_guard_pkg.sv ====
package emu_guard_pkg;

  // Emulator address space and block granularity
  localparam int          EMU_ADDR_W   = 16;
  localparam int          BLK_W        = 10;
  localparam int          ATTR_W       = 2;

  // Block attribute codes
  localparam logic [1:0]  ATTR_UNDEF   = 2'h0;
  localparam logic [1:0]  ATTR_RAM     = 2'h1;
  localparam logic [1:0]  ATTR_ROM     = 2'h2;
  localparam logic [1:0]  ATTR_GUARD   = 2'h3;

  // Register byte offsets
  localparam int          REG_AW       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_MAP_SEL  = 8'h08;
  localparam logic [7:0]  OFF_MAP_ATTR = 8'h0C;
  localparam logic [7:0]  OFF_LAST_OP  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0]  OFF_BRK_ADDR = 8'h1C;
  localparam logic [7:0]  OFF_CFG      = 8'h20;

  // Control bits (write-only pulses)
  localparam int          CTL_RUN      = 0;
  localparam int          CTL_BRK      = 1;
  localparam int          CTL_CLR      = 2;

  // Emulator status word bit positions
  localparam int          ST_CLK_MISS  = 12;
  localparam int          ST_BG_MODE   = 11;
  localparam int          ST_ILL_OP    = 10;
  localparam int          ST_MEM_BRK   = 9;
  localparam int          ST_BOARD_BRK = 8;

  // Interrupt event bits
  localparam int          EV_N         = 4;
  localparam int          EV_GUARD     = 0;
  localparam int          EV_UNDEF     = 1;
  localparam int          EV_ROM_WR    = 2;
  localparam int          EV_ILL_OP    = 3;

  // Reset values and response codes
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// ==== block_attr_map.sv ====
`timescale 1ns/1ps
`default_nettype none

module block_attr_map
  import emu_guard_pkg::*;
#(
  parameter int N_BLK = 64
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(N_BLK)-1:0] wr_idx,
  input  wire logic [ATTR_W-1:0]        wr_attr,
  input  wire logic [$clog2(N_BLK)-1:0] rd_idx,
  output logic      [ATTR_W-1:0]        rd_attr,
  input  wire logic [$clog2(N_BLK)-1:0] lk_idx,
  output logic      [ATTR_W-1:0]        lk_attr
);

  logic [ATTR_W-1:0] attr_q [N_BLK];

  // Each block keeps its own attribute, so ranges map independently
  for (genvar i = 0; i < N_BLK; i++) begin : g_blk
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        attr_q[i] <= ATTR_UNDEF;
      end else if (wr_en && (wr_idx == i)) begin
        attr_q[i] <= wr_attr;
      end
    end
  end

  assign rd_attr = attr_q[rd_idx];
  assign lk_attr = attr_q[lk_idx];

endmodule

`default_nettype wire

// ==== access_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module access_checker
  import emu_guard_pkg::*;
(
  input  wire logic              emu_valid,
  input  wire logic              emu_write,
  input  wire logic [ATTR_W-1:0] attr,
  input  wire logic              rom_brk_off,
  output logic                   hit_guard,
  output logic                   hit_undef,
  output logic                   hit_rom_wr
);

  // Only emulator cycles reach this check; host traffic uses the bus
  wire emu_cyc = emu_valid;

  assign hit_guard  = emu_cyc && (attr == ATTR_GUARD);
  assign hit_undef  = emu_cyc && (attr == ATTR_UNDEF);
  assign hit_rom_wr = emu_cyc && emu_write && (attr == ATTR_ROM)
                      && !rom_brk_off;

endmodule

`default_nettype wire

// ==== emu_mem_guard.sv ====
`timescale 1ns/1ps
`default_nettype none

module emu_mem_guard
  import emu_guard_pkg::*;
#(
  parameter int ADDR_W = EMU_ADDR_W,
  parameter int BLKS_W = BLK_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [REG_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [REG_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Emulator memory cycle
  input  wire logic              emu_valid,
  input  wire logic              emu_write,
  input  wire logic              emu_fetch,
  input  wire logic [ADDR_W-1:0] emu_addr,
  // Control board and pod status
  input  wire logic              ill_op,
  input  wire logic              bg_mode,
  input  wire logic              mclk_missing,
  input  wire logic              rom_wr_brk_off,
  // Break, run control and interrupt
  output logic                   brk_req,
  output logic                   host_brk,
  output logic                   emu_run,
  output logic                   irq
);

  localparam int N_BLK = 1 << (ADDR_W - BLKS_W);
  localparam int IDX_W = ADDR_W - BLKS_W;

  if (BLKS_W >= ADDR_W || IDX_W > 8) begin : g_chk
    $error("emu_mem_guard: block size must leave 1 to 8 index bits");
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel: address and data may come in any order
  // ---------------------------------------------------------------
  logic              aw_have_q;
  logic              aw_have_d;
  logic [REG_AW-1:0] aw_addr_q;
  logic              w_have_q;
  logic              w_have_d;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_have_q && w_have_q && !bvalid_q;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  assign aw_have_d = aw_take || (aw_have_q && !wr_go);
  assign w_have_d  = w_take || (w_have_q && !wr_go);
  assign bvalid_d  = wr_go || (bvalid_q && !s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
    end
  end

  // Write decode; every field lives in byte lane 0
  wire [REG_AW-1:0] wa = {aw_addr_q[REG_AW-1:2], 2'b00};
  wire [7:0]        wb = w_data_q[7:0];
  wire              wl = wr_go && w_strb_q[0];

  wire wr_known = (wa == OFF_CTRL) || (wa == OFF_STATUS) ||
                  (wa == OFF_MAP_SEL) || (wa == OFF_MAP_ATTR) ||
                  (wa == OFF_LAST_OP) || (wa == OFF_IRQ_STAT) ||
                  (wa == OFF_IRQ_MASK) || (wa == OFF_BRK_ADDR) ||
                  (wa == OFF_CFG);
  wire wr_ctrl  = wl && (wa == OFF_CTRL);
  wire wr_sel   = wl && (wa == OFF_MAP_SEL);
  wire wr_attr  = wl && (wa == OFF_MAP_ATTR);
  wire wr_istat = wl && (wa == OFF_IRQ_STAT);
  wire wr_imask = wl && (wa == OFF_IRQ_MASK);

  wire cmd_run = wr_ctrl && wb[CTL_RUN];
  wire cmd_brk = wr_ctrl && wb[CTL_BRK];
  wire cmd_clr = wr_ctrl && (wb[CTL_CLR] || wb[CTL_RUN]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end


  // ---------------------------------------------------------------
  // Block map
  // ---------------------------------------------------------------
  logic [IDX_W-1:0]  sel_q;
  logic [IDX_W-1:0]  sel_d;
  logic [ATTR_W-1:0] host_attr;
  logic [ATTR_W-1:0] emu_attr;

  wire [IDX_W-1:0] emu_idx = emu_addr[ADDR_W-1:BLKS_W];

  // Auto-increment after an attribute write so a range maps in a burst
  assign sel_d = wr_sel  ? wb[IDX_W-1:0] :
                 wr_attr ? IDX_W'(sel_q + 1'b1) : sel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

  block_attr_map #(
    .N_BLK (N_BLK)
  ) u_map (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_attr),
    .wr_idx  (sel_q),
    .wr_attr (wb[ATTR_W-1:0]),
    .rd_idx  (sel_q),
    .rd_attr (host_attr),
    .lk_idx  (emu_idx),
    .lk_attr (emu_attr)
  );

  // ---------------------------------------------------------------
  // Strap and access check
  // ---------------------------------------------------------------
  logic strap_q;
  logic hit_guard;
  logic hit_undef;
  logic hit_rom_wr;

  // Strap is static; caught while reset is held and frozen afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= rom_wr_brk_off;
    end
  end

  access_checker u_chk (
    .emu_valid   (emu_valid),
    .emu_write   (emu_write),
    .attr        (emu_attr),
    .rom_brk_off (strap_q),
    .hit_guard   (hit_guard),
    .hit_undef   (hit_undef),
    .hit_rom_wr  (hit_rom_wr)
  );

  wire mem_hit   = hit_guard || hit_undef || hit_rom_wr;
  wire other_brk = cmd_brk || ill_op;

  // ---------------------------------------------------------------
  // Break cause flags; a new event wins over a same-cycle clear
  // ---------------------------------------------------------------
  logic              mem_brk_q;
  logic              mem_brk_d;
  logic              board_q;
  logic              board_d;
  logic              ill_q;
  logic              ill_d;
  logic              brk_req_q;
  logic              host_brk_q;
  logic              emu_run_q;
  logic [ADDR_W-1:0] last_op_q;
  logic [ADDR_W-1:0] brk_addr_q;

  assign mem_brk_d = mem_hit || (mem_brk_q && !cmd_clr);
  assign board_d   = mem_hit || (board_q && !cmd_clr && !other_brk);
  assign ill_d     = ill_op || (ill_q && !cmd_clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_brk_q <= 1'b0;
      board_q   <= 1'b0;
      ill_q     <= 1'b0;
    end else begin
      mem_brk_q <= mem_brk_d;
      board_q   <= board_d;
      ill_q     <= ill_d;
    end
  end

  // Request stays up until the host restarts or clears, so a slow
  // control board cannot miss it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_req_q <= 1'b0;
    end else begin
      brk_req_q <= mem_hit || (brk_req_q && !cmd_clr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_brk_q <= 1'b0;
      emu_run_q  <= 1'b0;
    end else begin
      host_brk_q <= cmd_brk;
      emu_run_q  <= cmd_run;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_op_q  <= '0;
      brk_addr_q <= '0;
    end else begin
      if (emu_valid && emu_fetch) begin
        last_op_q <= emu_addr;
      end
      if (mem_hit) begin
        brk_addr_q <= emu_addr;
      end
    end
  end

  assign brk_req  = brk_req_q;
  assign host_brk = host_brk_q;
  assign emu_run  = emu_run_q;

  // ---------------------------------------------------------------
  // Interrupt status (write one to clear) and mask
  // ---------------------------------------------------------------
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] istat_q;
  logic [EV_N-1:0] istat_d;
  logic [EV_N-1:0] imask_q;

  assign ev[EV_GUARD]  = hit_guard;
  assign ev[EV_UNDEF]  = hit_undef;
  assign ev[EV_ROM_WR] = hit_rom_wr;
  assign ev[EV_ILL_OP] = ill_op;

  wire [EV_N-1:0] w1c = wr_istat ? wb[EV_N-1:0] : '0;

  assign istat_d = ev | (istat_q & ~w1c);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= '0;
      imask_q <= IRQ_MASK_RST;
    end else begin
      istat_q <= istat_d;
      if (wr_imask) begin
        imask_q <= wb[EV_N-1:0];
      end
    end
  end

  assign irq = |(istat_q & imask_q);

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [15:0] status_w;

  always_comb begin
    status_w               = 16'h0000;
    status_w[ST_CLK_MISS]  = mclk_missing;
    status_w[ST_BG_MODE]   = bg_mode;
    status_w[ST_ILL_OP]    = ill_q;
    status_w[ST_MEM_BRK]   = mem_brk_q;
    status_w[ST_BOARD_BRK] = board_q;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire              ar_take = s_axi_arvalid && s_axi_arready;
  wire [REG_AW-1:0] ra      = {s_axi_araddr[REG_AW-1:2], 2'b00};

  wire rd_status = (ra == OFF_STATUS);
  wire rd_sel    = (ra == OFF_MAP_SEL);
  wire rd_attr   = (ra == OFF_MAP_ATTR);
  wire rd_last   = (ra == OFF_LAST_OP);
  wire rd_istat  = (ra == OFF_IRQ_STAT);
  wire rd_imask  = (ra == OFF_IRQ_MASK);
  wire rd_baddr  = (ra == OFF_BRK_ADDR);
  wire rd_cfg    = (ra == OFF_CFG);
  wire rd_ctrl   = (ra == OFF_CTRL);
  wire rd_known  = rd_status || rd_sel || rd_attr || rd_last || rd_istat ||
                   rd_imask || rd_baddr || rd_cfg || rd_ctrl;

  // Control bits are pulses and read back as zero
  wire [31:0] rd_val =
    rd_status ? {16'h0000, status_w} :
    rd_sel    ? 32'(sel_q) :
    rd_attr   ? 32'(host_attr) :
    rd_last   ? 32'(last_op_q) :
    rd_istat  ? 32'(istat_q) :
    rd_imask  ? 32'(imask_q) :
    rd_baddr  ? 32'(brk_addr_q) :
    rd_cfg    ? 32'(strap_q) : 32'h0000_0000;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== emu_guard_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module emu_guard_sva (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        emu_valid,
  input  wire logic        brk_req,
  input  wire logic        host_brk,
  input  wire logic        emu_run
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_brk_cause;
    $rose(brk_req) |-> $past(emu_valid);
  endproperty
  a_brk_cause: assert property (p_brk_cause) else $error("break without cycle");
  property p_no_host;
    !emu_valid && !brk_req |=> !brk_req;
  endproperty
  a_no_host: assert property (p_no_host) else $error("spurious break");
  // Reset also drops the flag, so only falls seen out of reset count
  property p_hold;
    $fell(brk_req) && $past(aresetn) |-> $rose(s_axi_bvalid);
  endproperty
  a_hold: assert property (p_hold) else $error("break dropped unasked");
  property p_run;
    emu_run |-> !brk_req || $past(emu_valid);
  endproperty
  a_run: assert property (p_run) else $error("run left break set");
  property p_hbrk;
    host_brk |-> $rose(s_axi_bvalid) ##1 !host_brk;
  endproperty
  a_hbrk: assert property (p_hbrk) else $error("host break timing");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answered twice");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answered twice");
  c_brk: cover property ($rose(brk_req));
  c_hbrk: cover property (host_brk);
  c_run: cover property (emu_run);
endmodule
bind emu_mem_guard emu_guard_sva u_sva (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .emu_valid     (emu_valid),
  .brk_req       (brk_req),
  .host_brk      (host_brk),
  .emu_run       (emu_run)
);
`default_nettype wire

// ==== emu_pod_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module emu_pod_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic        fe,
  input  wire logic        bad,
  input  wire logic [15:0] addr,
  input  wire logic        host_brk,
  input  wire logic        emu_run,
  input  wire logic        brk_req,
  output logic             emu_valid,
  output logic             emu_write,
  output logic             emu_fetch,
  output logic [15:0]      emu_addr,
  output logic             ill_op
);
  logic halt_q;
  logic act;
  assign act = go & ~halt_q;
  // Idle cycles invert the last values so stale lines never look valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_q    <= 1'b0;
      emu_valid <= 1'b0;
      ill_op    <= 1'b0;
      emu_write <= 1'b0;
      emu_fetch <= 1'b0;
      emu_addr  <= 16'h0000;
    end else begin
      halt_q    <= (halt_q | host_brk | brk_req | ill_op) & ~emu_run;
      emu_valid <= act;
      ill_op    <= bad & ~halt_q;
      emu_write <= act ? wr : ~emu_write;
      emu_fetch <= act ? fe : ~emu_fetch;
      emu_addr  <= act ? addr : ~emu_addr;
    end
  end
endmodule
`default_nettype wire

// ==== tb_emulation_memory_break_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_emulation_memory_break_guard;
  import emu_guard_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, env;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, we;
  logic        emu_valid, emu_write, emu_fetch, ill_op, brk_req, host_brk, emu_run, irq;
  logic [15:0] emu_addr, addr = 16'h0, a;
  logic        bg_mode = 1'b0, mclk_missing = 1'b0, rom_wr_brk_off = 1'b0;
  logic        go = 1'b0, wr = 1'b0, fe = 1'b0, bad = 1'b0, hb, rn;
  logic [33:0] rq[$], re;
  logic [1:0]  wq[$];
  int          err_total = 0, n_checks = 0;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
  always #20 aclk = ~aclk;
  emu_mem_guard dut (.*);
  emu_pod_model pod (.aclk(aclk), .aresetn(aresetn), .go(go), .wr(wr), .fe(fe), .bad(bad),
    .addr(addr), .host_brk(host_brk), .emu_run(emu_run), .brk_req(brk_req),
    .emu_valid(emu_valid), .emu_write(emu_write), .emu_fetch(emu_fetch),
    .emu_addr(emu_addr), .ill_op(ill_op));
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, re)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      we = wq.pop_front();
      `CHK(s_axi_bresp, we)
    end
  end
  task automatic wr32(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
    logic aw, w;
    wq.push_back(r);
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= ad; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
    end while (!(aw && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    hb = host_brk;
    rn = emu_run;
    // Ready stays high so back-to-back calls never drive it twice in one step
  endtask
  task automatic rd32(input logic [7:0] ad, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask
  // The pod model adds one register stage before the design sees the cycle
  task automatic acc(input logic [15:0] ad, input logic w, input logic f, input logic b);
    addr <= ad; wr <= w; fe <= f; go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(brk_req, b)
  endtask
  task automatic rst(input logic s);
    aresetn <= 1'b0; rom_wr_brk_off <= s;
    bg_mode <= 1'($urandom_range(0, 1)); mclk_missing <= 1'($urandom_range(0, 1));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    env = {19'h0, mclk_missing, bg_mode, 11'h0};
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Table: block, write, fetch, break expected, event bit
  int blk[6] = '{0, 0, 2, 2, 3, 1};
  logic tw[6] = '{1, 0, 0, 1, 0, 0};
  logic tf[6] = '{0, 1, 1, 0, 0, 0};
  logic tb[6] = '{0, 0, 0, 1, 1, 1};
  int ev[6] = '{0, 0, 0, EV_ROM_WR, EV_GUARD, EV_UNDEF};
  logic [1:0] at[4] = '{ATTR_RAM, ATTR_UNDEF, ATTR_ROM, ATTR_GUARD};
  initial begin
    void'($urandom(32'h9F37));
    rst(1'b0);
    rd32(OFF_STATUS, env);
    rd32(OFF_IRQ_MASK, {28'h0, IRQ_MASK_RST});
    rd32(OFF_CFG, 32'h0);
    wr32(OFF_IRQ_MASK, 32'hF);
    wr32(OFF_MAP_SEL, 32'h0);
    foreach (at[i]) wr32(OFF_MAP_ATTR, {30'h0, at[i]});
    wr32(OFF_MAP_SEL, 32'h2);
    rd32(OFF_MAP_ATTR, {30'h0, ATTR_ROM});
    $display("test map done");
    foreach (blk[i]) begin
      a = 16'($urandom);
      a[15:10] = 6'(blk[i]);
      acc(a, tw[i], tf[i], tb[i]);
      if (tf[i]) rd32(OFF_LAST_OP, {16'h0, a});
      if (tb[i]) begin
        rd32(OFF_STATUS, env | 32'h300);
        rd32(OFF_IRQ_STAT, 32'h1 << ev[i]);
        rd32(OFF_BRK_ADDR, {16'h0, a});
        `CHK(irq, 1'b1)
        `CHK(brk_req, 1'b1)
        wr32(OFF_IRQ_STAT, 32'h1 << ev[i]);
        `CHK(irq, 1'b0)
        wr32(OFF_CTRL, 32'h1);
        `CHK(rn, 1'b1)
      end
    end
    $display("test access table done");
    wr32(OFF_IRQ_MASK, 32'h7);
    bad <= 1'b1;
    @(posedge aclk);
    bad <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd32(OFF_STATUS, env | 32'h400);
    rd32(OFF_IRQ_STAT, 32'h8);
    wr32(OFF_CTRL, 32'h1);
    $display("test opcode done");
    acc(16'h0C21, 1'b0, 1'b0, 1'b1);
    wr32(OFF_CTRL, 32'h2);
    `CHK(hb, 1'b1)
    rd32(OFF_STATUS, env | 32'h200);
    wr32(OFF_CTRL, 32'h4);
    `CHK(brk_req, 1'b0)
    wr32(OFF_CTRL, 32'h1);
    wr32(8'h24, 32'h1, RESP_SLVERR);
    rd32(8'h24, 32'h0, RESP_SLVERR);
    $display("test host break done");
    rst(1'b1);
    rd32(OFF_CFG, 32'h1);
    wr32(OFF_MAP_SEL, 32'h2);
    wr32(OFF_MAP_ATTR, {30'h0, ATTR_ROM});
    acc(16'h0A55, 1'b1, 1'b0, 1'b0);
    $display("test strap done");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
